// *** include/sos_pkg.sv ***
// Purpose: constants for the status output selector
// Assumes: 100 MHz clock
// Notes:   function codes, register offsets, timing figures
`default_nettype none
package sos_pkg;
	// ---------------------------------------------------------------
	// function codes
	// ---------------------------------------------------------------
	localparam logic [3:0] FN_OFF   = 4'h0;
	localparam logic [3:0] FN_READY = 4'h1;
	localparam logic [3:0] FN_POWER = 4'h2;
	localparam logic [3:0] FN_ZERO_SPEED_FLAG  = 4'h3;
	localparam logic [3:0] FN_SPEED_REACHED_FLAG  = 4'h4;
	localparam logic [3:0] FN_INPOS = 4'h5;
	localparam logic [3:0] FN_TQL   = 4'h6;
	localparam logic [3:0] FN_FAULT = 4'h7;
	localparam logic [3:0] FN_BRAKE = 4'h8;
	localparam logic [3:0] FN_OLW   = 4'h9;
	// ---------------------------------------------------------------
	// control modes
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_POS = 2'h0;
	localparam logic [1:0] MODE_SPD = 2'h1;
	localparam logic [1:0] MODE_TRQ = 2'h2;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] A_SEL    = 4'h0;
	localparam logic [3:0] A_ZERO_SPEED_FLAG   = 4'h1;
	localparam logic [3:0] A_SPEED_REACHED_FLAG   = 4'h2;
	localparam logic [3:0] A_INPOS  = 4'h3;
	localparam logic [3:0] A_TQA    = 4'h4;
	localparam logic [3:0] A_TQC    = 4'h5;
	localparam logic [3:0] A_OLWL   = 4'h6;
	localparam logic [3:0] A_BON    = 4'h7;
	localparam logic [3:0] A_BOFF   = 4'h8;
	localparam logic [3:0] A_CTRL   = 4'h9;
	localparam logic [3:0] A_STAT   = 4'hA;
	localparam logic [3:0] A_IRQST  = 4'hB;
	localparam logic [3:0] A_IRQCLR = 4'hC;
	localparam logic [3:0] A_IRQEN  = 4'hD;
	// ---------------------------------------------------------------
	// reset values and timing
	// ---------------------------------------------------------------
	localparam logic [15:0] ZERO_SPEED_FLAG_RST = 16'h000A; // 10 rpm
	localparam logic [15:0] SPEED_REACHED_FLAG_RST = 16'h0BB8;
	localparam logic [15:0] INPOS_RST = 16'h0064;
	localparam logic [15:0] TQ_RST   = 16'h0064;
	localparam logic [15:0] OLWL_RST = 16'h003C; // percent
	localparam int OL_PERMIT_MS      = 8000;     // at 200 % output
	localparam int CLK_MHZ           = 100;
	localparam int MS_CYCLES         = CLK_MHZ * 1000;
endpackage : sos_pkg
`default_nettype wire

// *** hdl/sos_top.sv ***
// Purpose: derive drive status conditions and route one to each output
// Assumes: speed, torque, position error are unsigned magnitudes
// Notes:   overload time counted in clock cycles
//
// Summary of operation
// R1 - powered code shows control power, faults ignored
// R2 - ready needs drive runnable and no fault or alarm
// R3 - zero speed while speed at or below threshold
// R4 - speed reached in speed mode, held until below target
// R5 - in position in position mode when position error at or below threshold
// R6 - torque limit when torque reaches limit, position or speed mode
// R7 - fault output whenever any fault is present
// R8 - brake output follows brake actuation with two delays
// R9 - warning time is permissible time times warning level percent
// R10 - warning output once unbroken overload time exceeds warning time, counter cleared when overload drops
// R11 - overload alarm once unbroken overload time exceeds permissible time
// R12 - permissible overload time is 8 seconds at 200 percent
// R13 - overload alarm also drives the fault output
// R14 - code zero holds the output inactive
// R15 - code one gives ready output
// R16 - each output picks any code, recomputed every cycle
// R17 - brake sequenced on servo-on with on and off delays
`default_nettype none
module sos_top #(
	parameter int NOUT     = 3,
	parameter int OL_LIMIT = sos_pkg::OL_PERMIT_MS * sos_pkg::MS_CYCLES
) (
	input  wire logic             clk_i,     // 100 MHz clock
	input  wire logic             srst_i,    // sync reset, high
	input  wire logic             power_i,   // control power present
	input  wire logic             can_run_i, // drive able to run
	input  wire logic             fault_i,   // any other fault
	input  wire logic             servo_on_i,// servo enabled
	input  wire logic             overload_i,// output at overload
	input  wire logic [1:0]       mode_i,    // control mode
	input  wire logic [15:0]      speed_i,   // measured speed rpm
	input  wire logic [15:0]      pos_err_i, // position error
	input  wire logic [15:0]      torque_i,  // measured torque
	input  wire logic [3:0]       addr_i,    // register address
	input  wire logic [15:0]      wdata_i,   // write data
	input  wire logic             wr_i,      // write strobe
	input  wire logic             rd_i,      // read strobe
	output logic      [15:0]      rdata_o,   // read data
	output logic      [NOUT-1:0]  dout_o,    // digital outputs
	output logic                  alarm_o,   // overload alarm shown
	output logic                  irq_o      // interrupt level
);
	// refuse settings that the selector and the timers cannot serve
	if (NOUT < 1 || NOUT > 4 || OL_LIMIT < 100) begin : g_bad_param
		$error("sos_top: bad parameters");
	end

	// every check below runs on the one clock and rests during reset
	default clocking chk_cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [15:0] sel_q, zero_speed_flag_q, speed_reached_flag_q, inpos_q, tqa_q, tqc_q;
	logic [15:0] olwl_q, bon_q, boff_q;
	logic        rdy_gate_q;
	logic [4:0]  irq_st_q, irq_en_q;
	logic        ol_alarm_q, spd_hit_q, brake_q;
	logic [31:0] ol_cnt_q;
	logic [47:0] btmr_q;    // wide enough for the longest delay in cycles
	logic        son_q;

	// write decode
	wire w_sel   = wr_i && addr_i == sos_pkg::A_SEL;
	wire w_ctrl  = wr_i && addr_i == sos_pkg::A_CTRL;
	wire w_clr   = wr_i && addr_i == sos_pkg::A_IRQCLR;
	wire w_en    = wr_i && addr_i == sos_pkg::A_IRQEN;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sel_q      <= 16'h0000;
			zero_speed_flag_q     <= sos_pkg::ZERO_SPEED_FLAG_RST;
			speed_reached_flag_q     <= sos_pkg::SPEED_REACHED_FLAG_RST;
			inpos_q    <= sos_pkg::INPOS_RST;
			tqa_q      <= sos_pkg::TQ_RST;
			tqc_q      <= sos_pkg::TQ_RST;
			olwl_q     <= sos_pkg::OLWL_RST;
			bon_q      <= 16'h0000;
			boff_q     <= 16'h0000;
			rdy_gate_q <= 1'b1;
			irq_en_q   <= 5'h00;
		end else if (wr_i) begin
			if (w_sel) sel_q <= wdata_i;
			else if (addr_i == sos_pkg::A_ZERO_SPEED_FLAG) zero_speed_flag_q <= wdata_i;
			else if (addr_i == sos_pkg::A_SPEED_REACHED_FLAG) speed_reached_flag_q <= wdata_i;
			else if (addr_i == sos_pkg::A_INPOS) inpos_q <= wdata_i;
			else if (addr_i == sos_pkg::A_TQA) tqa_q <= wdata_i;
			else if (addr_i == sos_pkg::A_TQC) tqc_q <= wdata_i;
			else if (addr_i == sos_pkg::A_OLWL) olwl_q <= wdata_i;
			else if (addr_i == sos_pkg::A_BON) bon_q <= wdata_i;
			else if (addr_i == sos_pkg::A_BOFF) boff_q <= wdata_i;
			else if (w_ctrl) rdy_gate_q <= wdata_i[0];
			else if (w_en) irq_en_q <= wdata_i[4:0];
		end
	end

	// ---------------------------------------------------------------
	// condition flags
	// ---------------------------------------------------------------
	wire is_pos = mode_i == sos_pkg::MODE_POS;
	wire is_spd = mode_i == sos_pkg::MODE_SPD;
	wire any_fault = fault_i | ol_alarm_q;                          // R13
	wire powered_indicator = power_i;                               // R1
	wire ready_indicator = power_i & can_run_i & ~any_fault
		& rdy_gate_q;                                               // R2
	wire zero_speed_flag = speed_i <= zero_speed_flag_q;                       // R3
	wire speed_reached_flag = is_spd & spd_hit_q;                   // R4
	wire in_position_flag = is_pos & (pos_err_i <= inpos_q);        // R5
	wire torque_limit_hit = (is_pos | is_spd)
		& (torque_i >= tqa_q || torque_i >= tqc_q);                 // R6

	// speed reached latches until speed drops below target
	always_ff @(posedge clk_i) begin
		if (srst_i) spd_hit_q <= 1'b0;
		else spd_hit_q <= (speed_i >= speed_reached_flag_q) ? 1'b1 :
			(speed_i < speed_reached_flag_q) ? 1'b0 : spd_hit_q;                  // R4
	end

	// ---------------------------------------------------------------
	// overload timer
	// ---------------------------------------------------------------
	// warning time = permit * level / 100
	wire [31:0] olw_time = 32'((64'(OL_LIMIT) * 64'(olwl_q))
		/ 64'd100);                                                 // R9 R12
	wire overload_warning_output = ol_cnt_q > olw_time;            // R10
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ol_cnt_q   <= 32'h0000_0000;
			ol_alarm_q <= 1'b0;
		end else begin
			ol_cnt_q <= overload_i ? ((ol_cnt_q == 32'hFFFF_FFFF) ?
				ol_cnt_q : ol_cnt_q + 32'h0000_0001) : 32'h0000_0000; // R10
			if (ol_cnt_q > 32'(OL_LIMIT)) ol_alarm_q <= 1'b1;       // R11
		end
	end

	// ---------------------------------------------------------------
	// brake sequencer: release after on delay, engage after off delay
	// or when speed falls to the zero speed threshold
	// ---------------------------------------------------------------
	// full 16-bit delays in ms overflow 32 bits of cycles, so go wider
	wire [47:0] bon_cyc  = 48'(bon_q) * 48'(sos_pkg::MS_CYCLES);
	wire [47:0] boff_cyc = 48'(boff_q) * 48'(sos_pkg::MS_CYCLES);
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			son_q   <= 1'b0;
			brake_q <= 1'b0;
			btmr_q  <= 48'h0000_0000_0000;
		end else begin
			son_q <= servo_on_i;
			if (servo_on_i != son_q)
				btmr_q <= 48'h0000_0000_0000;
			else if (btmr_q != 48'hFFFF_FFFF_FFFF)
				btmr_q <= btmr_q + 48'h0000_0000_0001;
			if (servo_on_i && son_q && btmr_q >= bon_cyc)
				brake_q <= 1'b1;                                    // R8 R17
			else if (!servo_on_i && !son_q &&
				(btmr_q >= boff_cyc || zero_speed_flag))
				brake_q <= 1'b0;                                    // R17
		end
	end

	// brake release and engage each follow one settled servo state
	sequence servo_held_s;
		servo_on_i && son_q && btmr_q >= bon_cyc;
	endsequence
	sequence servo_dropped_s;
		!servo_on_i && !son_q && (btmr_q >= boff_cyc || zero_speed_flag);
	endsequence
	brake_on_a: assert property ( // R17
		servo_held_s |=> brake_q)
		else $error("brake not released after on delay");
	brake_off_a: assert property ( // R17
		servo_dropped_s |=> !brake_q)
		else $error("brake not engaged after off delay");

	// ---------------------------------------------------------------
	// output selection
	// ---------------------------------------------------------------
	function automatic logic pick(input logic [3:0] code,
		input logic [9:0] f);
		pick = (code != sos_pkg::FN_OFF && code <= sos_pkg::FN_OLW)
			? f[code] : 1'b0;                                       // R14
	endfunction : pick

	wire [9:0] flags = {overload_warning_output, brake_q, any_fault,
		torque_limit_hit, in_position_flag, speed_reached_flag,
		zero_speed_flag, powered_indicator, ready_indicator,
		1'b0};                                                      // R15 R7

	always_ff @(posedge clk_i) begin
		if (srst_i) dout_o <= '0;
		else for (int i = 0; i < NOUT; i++)
			dout_o[i] <= pick(sel_q[4*i +: 4], flags);              // R16
	end

	// ---------------------------------------------------------------
	// interrupts: alarm, warning, fault, ready, brake rising events
	// ---------------------------------------------------------------
	logic [4:0] ev_prev_q;
	wire  [4:0] ev_now  = {ol_alarm_q, overload_warning_output,
		any_fault, ready_indicator, brake_q};
	wire  [4:0] ev_rise = ev_now & ~ev_prev_q;
	wire  [4:0] clr_m   = w_clr ? wdata_i[4:0] : 5'h00;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ev_prev_q <= 5'h00;
			irq_st_q  <= 5'h00;
			irq_o     <= 1'b0;
			alarm_o   <= 1'b0;
		end else begin
			ev_prev_q <= ev_now;
			irq_st_q  <= (irq_st_q & ~clr_m) | ev_rise;
			irq_o     <= |(((irq_st_q & ~clr_m) | ev_rise) & irq_en_q);
			alarm_o   <= ol_alarm_q;                                // R11
		end
	end

	// a rising event always lands in status; the level follows status
	irq_set_a: assert property (
		ev_rise != 5'h00 |=> (irq_st_q & $past(ev_rise)) == $past(ev_rise))
		else $error("interrupt event lost");
	irq_lvl_a: assert property (
		1'b1 |=> irq_o == |(irq_st_q & $past(irq_en_q)))
		else $error("interrupt level wrong");

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	wire [15:0] stat = {7'h00, ol_alarm_q, overload_warning_output,
		brake_q, torque_limit_hit, in_position_flag,
		speed_reached_flag, zero_speed_flag, ready_indicator,
		powered_indicator};
	wire [15:0] rmux =
		addr_i == sos_pkg::A_SEL   ? sel_q :
		addr_i == sos_pkg::A_ZERO_SPEED_FLAG  ? zero_speed_flag_q :
		addr_i == sos_pkg::A_SPEED_REACHED_FLAG  ? speed_reached_flag_q :
		addr_i == sos_pkg::A_INPOS ? inpos_q :
		addr_i == sos_pkg::A_TQA   ? tqa_q :
		addr_i == sos_pkg::A_TQC   ? tqc_q :
		addr_i == sos_pkg::A_OLWL  ? olwl_q :
		addr_i == sos_pkg::A_BON   ? bon_q :
		addr_i == sos_pkg::A_BOFF  ? boff_q :
		addr_i == sos_pkg::A_CTRL  ? {15'h0000, rdy_gate_q} :
		addr_i == sos_pkg::A_STAT  ? stat :
		addr_i == sos_pkg::A_IRQST ? {11'h000, irq_st_q} :
		addr_i == sos_pkg::A_IRQEN ? {11'h000, irq_en_q} : 16'h0000;
	always_ff @(posedge clk_i) begin
		if (srst_i) rdata_o <= 16'h0000;
		else rdata_o <= rd_i ? rmux : 16'h0000;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	zero_off_a: assert property ( // R14
		sel_q[3:0] == sos_pkg::FN_OFF |=> !dout_o[0])
		else $error("disabled output active");
	power_sel_a: assert property ( // R1
		sel_q[3:0] == sos_pkg::FN_POWER |=> dout_o[0] == $past(power_i))
		else $error("powered output wrong");
	ready_sel_a: assert property ( // R15
		sel_q[3:0] == sos_pkg::FN_READY
		|=> dout_o[0] == $past(ready_indicator))
		else $error("ready output wrong");
	fault_sel_a: assert property ( // R7
		sel_q[3:0] == sos_pkg::FN_FAULT |=> dout_o[0] == $past(any_fault))
		else $error("fault output wrong");
	ready_flt_a: assert property ( // R2
		any_fault |-> !ready_indicator)
		else $error("ready during fault");
	zero_speed_flag_cmp_a: assert property ( // R3
		speed_i > zero_speed_flag_q |-> !zero_speed_flag)
		else $error("zero speed above threshold");
	speed_reached_flag_mode_a: assert property ( // R4
		!is_spd |-> !speed_reached_flag)
		else $error("speed reached outside speed mode");
	speed_reached_flag_hold_a: assert property ( // R4
		is_spd && speed_i >= speed_reached_flag_q |=> speed_reached_flag || !is_spd)
		else $error("speed reached not raised");
	inpos_mode_a: assert property ( // R5
		is_pos && pos_err_i <= inpos_q |-> in_position_flag)
		else $error("in position missed");
	tql_mode_a: assert property ( // R6
		mode_i == sos_pkg::MODE_TRQ |-> !torque_limit_hit)
		else $error("torque limit in torque mode");
	alarm_flt_a: assert property ( // R13
		ol_alarm_q |-> any_fault && !ready_indicator)
		else $error("alarm not a fault");
	ol_alarm_a: assert property ( // R11
		overload_i && ol_cnt_q > 32'(OL_LIMIT) |=> ol_alarm_q)
		else $error("overload alarm late");
	alarm_hold_a: assert property ( // R11
		ol_alarm_q |=> ol_alarm_q)
		else $error("overload alarm dropped");
	olw_clr_a: assert property ( // R10
		!overload_i |=> !overload_warning_output)
		else $error("warning without overload");
	rdata_idle_a: assert property (
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data outside read cycle");
endmodule : sos_top
`default_nettype wire

// *** dv/sos_ctrl_model.sv ***
// Purpose: machine controller that samples the drive's digital outputs
// Assumes: the controller reads the outputs once per clock
// Notes:   holds the last sampled word for the bench to inspect
`default_nettype none
module sos_ctrl_model (
	input  wire logic       clk_i,  // controller clock
	input  wire logic [2:0] dout_i, // drive digital outputs
	output logic      [2:0] seen_o  // last sampled outputs
);
	timeunit 1ns;
	timeprecision 1ps;
	// sample the outputs at every rising edge, as a polling controller would
	always_ff @(posedge clk_i) begin
		seen_o <= dout_i;
	end
endmodule : sos_ctrl_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the status output selector
// Assumes: overload limit shortened to 1000 cycles
// Notes:   register tasks plus checks on the output pins
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	localparam int OLL = 1000;
	logic clk_i = 1'b0, srst_i = 1'b1, power_i = 1'b0, can_run_i = 1'b0;
	logic fault_i = 1'b0, servo_on_i = 1'b0, overload_i = 1'b0;
	logic wr_i = 1'b0, rd_i = 1'b0;
	logic [1:0] mode_i = sos_pkg::MODE_SPD;
	logic [15:0] speed_i = 16'h0000, pos_err_i = 16'h0000;
	logic [15:0] torque_i = 16'h0000, wdata_i = 16'h0000;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] rdata_o;
	logic [2:0] dout_o, seen;
	logic alarm_o, irq_o;
	int n_fail = 0, num_checks = 0, cyc = 0;
	sos_top #(.NOUT(3), .OL_LIMIT(OLL)) u_dut (.clk_i(clk_i),
		.srst_i(srst_i), .power_i(power_i), .can_run_i(can_run_i),
		.fault_i(fault_i), .servo_on_i(servo_on_i),
		.overload_i(overload_i), .mode_i(mode_i), .speed_i(speed_i),
		.pos_err_i(pos_err_i), .torque_i(torque_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.dout_o(dout_o), .alarm_o(alarm_o), .irq_o(irq_o));
	sos_ctrl_model u_ctrl (.clk_i(clk_i), .dout_i(dout_o), .seen_o(seen));
	// clock and hang guard
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic cmp_reg(input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t exp %h got %h", $time, exp, got);
		end
	endtask : cmp_reg
	task automatic cmp_pin(input logic [3:0] exp, input logic [3:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t exp %h got %h", $time, exp, got);
		end
	endtask : cmp_pin
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		cmp_reg(exp, rdata_o);
	endtask : rd
	// output 0 takes a, output 1 b, output 2 c
	task automatic sel(input logic [3:0] a, b, c);
		wr(sos_pkg::A_SEL, {4'h0, c, b, a});
	endtask : sel
	// returns on an edge so that the next drive lands on that edge
	task automatic pins(input logic [3:0] exp);
		step(3);
		cmp_pin(exp, {1'b0, dout_o});
		@(posedge clk_i);
	endtask : pins
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(sos_pkg::A_ZERO_SPEED_FLAG, 16'h000A);
		rd(sos_pkg::A_SPEED_REACHED_FLAG, 16'h0BB8);
		rd(sos_pkg::A_INPOS, 16'h0064);
		rd(sos_pkg::A_OLWL, 16'h003C);
		rd(4'hF, 16'h0000);
		@(posedge clk_i);
		power_i <= 1'b1;
		can_run_i <= 1'b1;
		pins(4'h0);
		$display("test reset done");
		sel(sos_pkg::FN_POWER, sos_pkg::FN_READY, sos_pkg::FN_FAULT);
		pins(4'h3);
		fault_i <= 1'b1;
		pins(4'h5);
		fault_i <= 1'b0;
		wr(sos_pkg::A_CTRL, 16'h0000);
		pins(4'h1);
		wr(sos_pkg::A_CTRL, 16'h0001);
		rd(sos_pkg::A_CTRL, 16'h0001);
		$display("test power ready fault done");
		sel(sos_pkg::FN_ZERO_SPEED_FLAG, sos_pkg::FN_SPEED_REACHED_FLAG, sos_pkg::FN_INPOS);
		speed_i <= 16'h000A;
		pins(4'h1);
		speed_i <= 16'h000B;
		pins(4'h0);
		speed_i <= 16'h0BB8;
		pins(4'h2);
		speed_i <= 16'h0BB7;
		pins(4'h0);
		speed_i <= 16'h0BB8;
		mode_i <= sos_pkg::MODE_POS;
		pos_err_i <= 16'h0064;
		pins(4'h4);
		pos_err_i <= 16'h0065;
		pins(4'h0);
		$display("test speed position done");
		sel(sos_pkg::FN_TQL, 4'hF, sos_pkg::FN_OFF);
		torque_i <= 16'h0064;
		pins(4'h1);
		torque_i <= 16'h0063;
		pins(4'h0);
		wr(sos_pkg::A_TQC, 16'h0032);
		pins(4'h1);
		mode_i <= sos_pkg::MODE_TRQ;
		pins(4'h0);
		$display("test torque done");
		speed_i <= 16'h0000;
		wr(sos_pkg::A_IRQEN, 16'h0001);
		sel(sos_pkg::FN_BRAKE, sos_pkg::FN_OFF, sos_pkg::FN_OFF);
		servo_on_i <= 1'b1;
		pins(4'h1);
		#1;
		cmp_pin(4'h1, {3'h0, irq_o});
		rd(sos_pkg::A_IRQST, 16'h0007);
		wr(sos_pkg::A_IRQEN, 16'h0000);
		step(2);
		cmp_pin(4'h0, {3'h0, irq_o});
		wr(sos_pkg::A_IRQEN, 16'h0001);
		wr(sos_pkg::A_IRQCLR, 16'h0001);
		step(2);
		cmp_pin(4'h0, {3'h0, irq_o});
		rd(sos_pkg::A_IRQST, 16'h0006);
		@(posedge clk_i);
		servo_on_i <= 1'b0;
		pins(4'h0);
		$display("test brake interrupt done");
		wr(sos_pkg::A_IRQEN, 16'h0010);
		sel(sos_pkg::FN_OLW, sos_pkg::FN_FAULT, sos_pkg::FN_POWER);
		overload_i <= 1'b1;
		step(590);
		cmp_pin(4'h4, {1'b0, dout_o});
		step(25);
		cmp_pin(4'h5, {1'b0, dout_o});
		step(385);
		cmp_pin(4'h0, {3'h0, alarm_o});
		step(20);
		cmp_pin(4'h1, {3'h0, alarm_o});
		cmp_pin(4'h7, {1'b0, dout_o});
		cmp_pin(4'h1, {3'h0, irq_o});
		@(posedge clk_i);
		overload_i <= 1'b0;
		pins(4'h6);
		#1;
		cmp_pin(4'h1, {3'h0, alarm_o});
		cmp_pin(4'h6, {1'b0, seen});
		rd(sos_pkg::A_STAT, 16'h0105);
		$display("test overload done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
